// ==== inc/jtm_pkg.sv ====
// Constants, field layouts and helpers shared by the transport sample mapper
package jtm_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int NUM_LANES = 8;
    localparam int NUM_CH = 4;
    localparam int SMP_PER_CH = 10;
    localparam int SMP_W = 9;
    localparam int OCTET_W = 8;
    localparam int FRAME_W = 64;
    localparam int WORD12_W = 12;
    localparam int WORD10_W = 10;
    localparam int MODE_W = 4;
    localparam int CNT_W = 4;

    // ----------------------------------------
    // Link modes and channel configurations
    // ----------------------------------------
    localparam logic [MODE_W-1:0] LAST_MODE = 4'h6;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_DUAL = 2'h1;
    localparam logic [1:0] CFG_QUAD = 2'h2;
    localparam logic [2:0] CH_SINGLE = 3'h1;
    localparam logic [2:0] CH_DUAL = 3'h2;
    localparam logic [2:0] CH_QUAD = 3'h4;

    // Per-mode tables, index = link mode 0..6 (rightmost entry is mode 0)
    localparam logic [6:0][CNT_W-1:0] FRAME_OCTETS = {4'h2, 4'h2, 4'h2, 4'h5, 4'h1, 4'h2, 4'h8};
    localparam logic [6:0][CNT_W-1:0] LANES_QUAD = {4'h6, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8};
    localparam logic [6:0][CNT_W-1:0] LANES_DUAL = {4'h3, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4};
    localparam logic [6:0][CNT_W-1:0] LANES_SINGLE = {4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2};

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [NUM_LANES-1:0] LANE_EN_RST = 8'h00;

    // Nine-bit sample followed by three zero padding bits
    function automatic logic [WORD12_W-1:0] jtm_pad12(input logic [SMP_W-1:0] x);
        return {x, 3'h0};
    endfunction

endpackage

// ==== src/jtm_lane_shift.sv ====
// One lane: holds a left-aligned frame and emits it an octet per clock, MSB first
`timescale 1ns/1ps
module jtm_lane_shift
    import jtm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic load_i,
    input wire logic shift_i,
    input wire logic enable_i,
    input wire logic [FRAME_W-1:0] frame_i,
    // Lane octet
    output logic [OCTET_W-1:0] octet_o
);

    typedef struct packed {
        logic [FRAME_W-1:0] shreg;
        logic [OCTET_W-1:0] octet;
    } jtm_shift_t;

    jtm_shift_t s;
    jtm_shift_t next_s;

    always_comb
    begin
        next_s = s;
        if (load_i)
        begin
            // A powered-down lane carries zeros only
            next_s.octet = enable_i ? frame_i[FRAME_W-1 -: OCTET_W] : '0; // RULE14
            next_s.shreg = enable_i ? {frame_i[FRAME_W-OCTET_W-1:0], 8'h00} : '0; // RULE13
        end
        else if (shift_i)
        begin
            next_s.octet = s.shreg[FRAME_W-1 -: OCTET_W]; // RULE13
            next_s.shreg = {s.shreg[FRAME_W-OCTET_W-1:0], 8'h00};
        end
        else
        begin
            next_s.octet = '0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign octet_o = s.octet;

endmodule

// ==== src/jtm_sample_mapper.sv ====
// Transport-layer sample mapper: packs channel samples into per-lane octet frames
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Mode 0: five padded samples, tail, 8/4/2
// RULE2 - Mode 0: lane pair per channel, even/odd
// RULE3 - Mode 1: lane 0/1 split of A samples
// RULE4 - Mode 1: B0 split, zero when absent
// RULE5 - Mode 2: one 8-bit sample per lane
// RULE6 - Mode 3: four 9-bit samples, one zero each
// RULE7 - Mode 4: A0 padded then B0 high nibble
// RULE8 - Mode 4: lanes 1 and 2 carry B,C,D
// RULE9 - Mode 5: lane 0 holds A0 then B0
// RULE10 - Mode 6: same packing as mode 1
// RULE11 - Mode 6: lane 2 and lanes 3-5 split
// RULE12 - Tail and padding bits driven zero
// RULE13 - Samples sent MSB first
// RULE14 - Lowest lanes used, upper lanes powered down
// RULE15 - Mode 5 quad: lane 1 holds C0, D0
module jtm_sample_mapper
    import jtm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic [MODE_W-1:0] link_mode_select_i,
    input wire logic [1:0] chan_cfg_i,
    // Sample frame in, index [channel][sample], channel 0 is A
    input wire logic frame_valid_i,
    input wire logic [NUM_CH-1:0][SMP_PER_CH-1:0][SMP_W-1:0] sample_i,
    output logic frame_ready_o,
    // Lane octets out
    output logic octet_valid_o,
    output logic frame_start_o,
    output logic [NUM_LANES-1:0] lane_en_o,
    output logic [OCTET_W-1:0] lane_0_o,
    output logic [OCTET_W-1:0] lane_1_o,
    output logic [OCTET_W-1:0] lane_2_o,
    output logic [OCTET_W-1:0] lane_3_o,
    output logic [OCTET_W-1:0] lane_4_o,
    output logic [OCTET_W-1:0] lane_5_o,
    output logic [OCTET_W-1:0] lane_6_o,
    output logic [OCTET_W-1:0] lane_7_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic ready;
        logic octet_valid;
        logic frame_start;
        logic [NUM_LANES-1:0] lane_en;
    } jtm_state_t;

    localparam jtm_state_t STATE_RST = '{count: CNT_RST, ready: 1'b1, octet_valid: 1'b0,
                                         frame_start: 1'b0, lane_en: LANE_EN_RST};

    jtm_state_t s;
    jtm_state_t next_s;
    logic take;
    logic supported;
    logic [2:0] num_ch;
    logic [CNT_W-1:0] num_lanes;
    logic [CNT_W-1:0] octets;
    logic [NUM_LANES-1:0] lane_mask;
    logic [NUM_CH-1:0][SMP_PER_CH-1:0][SMP_W-1:0] smp;
    logic [NUM_LANES-1:0][FRAME_W-1:0] frame_map;
    logic [NUM_LANES-1:0][OCTET_W-1:0] lane_octet;

    assign take = frame_valid_i & s.ready;
    assign supported = (link_mode_select_i <= LAST_MODE);

    // ----------------------------------------
    // Lane and frame geometry for the selected mode
    // ----------------------------------------
    always_comb
    begin
        num_ch = CH_QUAD;
        num_lanes = '0;
        octets = 4'h1;
        if (supported)
        begin
            octets = FRAME_OCTETS[link_mode_select_i[2:0]];
            unique case (chan_cfg_i)
                CFG_SINGLE:
                begin
                    num_ch = CH_SINGLE;
                    num_lanes = LANES_SINGLE[link_mode_select_i[2:0]];
                end
                CFG_DUAL:
                begin
                    num_ch = CH_DUAL;
                    num_lanes = LANES_DUAL[link_mode_select_i[2:0]];
                end
                default:
                begin
                    num_ch = CH_QUAD;
                    num_lanes = LANES_QUAD[link_mode_select_i[2:0]];
                end
            endcase
        end
        for (int i = 0; i < NUM_LANES; i++)
            lane_mask[i] = (i < int'(num_lanes)); // RULE14
        // Absent channels are forced to zero so their slots fill with zeros
        for (int c = 0; c < NUM_CH; c++)
            smp[c] = (c < int'(num_ch)) ? sample_i[c] : '0; // RULE4 RULE9
    end

    // ----------------------------------------
    // Frame mapping, left aligned, unused bits zero
    // ----------------------------------------
    always_comb
    begin
        frame_map = '0; // RULE12
        unique case (link_mode_select_i)
            4'h0:
            begin
                for (int c = 0; c < NUM_CH; c++)
                    for (int e = 0; e < 2; e++)
                        for (int k = 0; k < 5; k++)
                            frame_map[2*c+e][FRAME_W-1-WORD12_W*k -: WORD12_W] =
                                jtm_pad12(smp[c][2*k+e]); // RULE1 RULE2
            end
            4'h1, 4'h6:
            begin
                for (int p = 0; p < 2; p++)
                begin
                    frame_map[3*p][FRAME_W-1 -: 16] =
                        {jtm_pad12(smp[2*p][0]), smp[2*p][1][8:5]}; // RULE3 RULE10
                    frame_map[3*p+1][FRAME_W-1 -: 16] =
                        {smp[2*p][1][4:0], 3'h0, smp[2*p+1][0][8:1]}; // RULE4 RULE10
                    frame_map[3*p+2][FRAME_W-1 -: 16] =
                        {smp[2*p+1][0][0], 3'h0, jtm_pad12(smp[2*p+1][1])}; // RULE4 RULE11
                end
            end
            4'h2:
            begin
                // Eight-bit modes carry the top eight sample bits
                for (int c = 0; c < NUM_CH; c++)
                    frame_map[c][FRAME_W-1 -: OCTET_W] = smp[c][0][8:1]; // RULE5
            end
            4'h3:
            begin
                for (int c = 0; c < NUM_CH; c++)
                    for (int k = 0; k < 4; k++)
                        frame_map[c][FRAME_W-1-WORD10_W*k -: WORD10_W] = {smp[c][k], 1'b0}; // RULE6
            end
            4'h4:
            begin
                frame_map[0][FRAME_W-1 -: 16] = {jtm_pad12(smp[0][0]), smp[1][0][8:5]}; // RULE7
                frame_map[1][FRAME_W-1 -: 16] = {smp[1][0][4:0], 3'h0, smp[2][0][8:1]}; // RULE8
                frame_map[2][FRAME_W-1 -: 16] = {smp[2][0][0], 3'h0, jtm_pad12(smp[3][0])}; // RULE8
            end
            4'h5:
            begin
                frame_map[0][FRAME_W-1 -: 16] = {smp[0][0][8:1], smp[1][0][8:1]}; // RULE9
                frame_map[1][FRAME_W-1 -: 16] = {smp[2][0][8:1], smp[3][0][8:1]}; // RULE15
            end
            default:
            begin
                frame_map = '0;
            end
        endcase
    end

    // ----------------------------------------
    // Frame sequencing
    // ----------------------------------------
    always_comb
    begin
        next_s = s;
        if (take)
        begin
            next_s.count = octets - 4'h1;
            next_s.octet_valid = 1'b1;
            next_s.frame_start = 1'b1;
            next_s.lane_en = lane_mask; // RULE14
        end
        else if (s.count != '0)
        begin
            next_s.count = s.count - 4'h1;
            next_s.octet_valid = 1'b1;
            next_s.frame_start = 1'b0;
        end
        else
        begin
            next_s.octet_valid = 1'b0;
            next_s.frame_start = 1'b0;
        end
        next_s.ready = (next_s.count == '0);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            s <= STATE_RST;
        else
            s <= next_s;
    end

    // ----------------------------------------
    // Lane serialisers
    // ----------------------------------------
    for (genvar g = 0; g < NUM_LANES; g++)
    begin : g_lane
        jtm_lane_shift u_shift (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .load_i(take),
            .shift_i(s.count != '0),
            .enable_i(lane_mask[g]),
            .frame_i(frame_map[g]),
            .octet_o(lane_octet[g])
        );
    end

    assign frame_ready_o = s.ready;
    assign octet_valid_o = s.octet_valid;
    assign frame_start_o = s.frame_start;
    assign lane_en_o = s.lane_en;
    assign lane_0_o = lane_octet[0];
    assign lane_1_o = lane_octet[1];
    assign lane_2_o = lane_octet[2];
    assign lane_3_o = lane_octet[3];
    assign lane_4_o = lane_octet[4];
    assign lane_5_o = lane_octet[5];
    assign lane_6_o = lane_octet[6];
    assign lane_7_o = lane_octet[7];

endmodule

// ==== verif/jtm_sample_mapper_monitor.sv ====
// Port checks for the transport sample mapper
`timescale 1ns/1ps
module jtm_sample_mapper_monitor
    import jtm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Inputs
    input wire logic [MODE_W-1:0] link_mode_select_i,
    input wire logic [1:0] chan_cfg_i,
    input wire logic frame_valid_i,
    input wire logic [NUM_CH-1:0][SMP_PER_CH-1:0][SMP_W-1:0] sample_i,
    // Outputs
    input wire logic frame_ready_o,
    input wire logic octet_valid_o,
    input wire logic frame_start_o,
    input wire logic [NUM_LANES-1:0] lane_en_o,
    input wire logic [OCTET_W-1:0] lane_0_o,
    input wire logic [OCTET_W-1:0] lane_1_o,
    input wire logic [OCTET_W-1:0] lane_2_o,
    input wire logic [OCTET_W-1:0] lane_3_o,
    input wire logic [OCTET_W-1:0] lane_4_o,
    input wire logic [OCTET_W-1:0] lane_5_o,
    input wire logic [OCTET_W-1:0] lane_6_o,
    input wire logic [OCTET_W-1:0] lane_7_o
);
    logic take;
    logic [3:0] fq, oc, idx, nl;
    logic [63:0] all;
    logic [7:0] nz;
    logic [2:0] m;
    logic [7:0] exp_en;
    logic [7:0] b0_hi;

    // ----------------------------------------
    // Frame position tracking
    // ----------------------------------------
    always_comb
    begin
        take = frame_valid_i && frame_ready_o;
        idx = frame_start_o ? 4'h0 : oc;
        all = {lane_7_o, lane_6_o, lane_5_o, lane_4_o, lane_3_o, lane_2_o, lane_1_o, lane_0_o};
        m = link_mode_select_i[2:0];
        for (int i = 0; i < 8; i++)
            nz[i] = |all[8 * i +: 8];
        nl = (chan_cfg_i == CFG_SINGLE) ? LANES_SINGLE[m] : (chan_cfg_i == CFG_DUAL) ? LANES_DUAL[m] : LANES_QUAD[m];
        if (link_mode_select_i > LAST_MODE)
            nl = 4'h0;
        // Held in plain signals so that the sampled-value function sees a signal
        exp_en = 8'((9'h1 << nl) - 9'h1);
        b0_hi = sample_i[1][0][8:1];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            fq <= 4'h1;
            oc <= 4'h0;
        end
        else
        begin
            if (take)
                fq <= (link_mode_select_i > LAST_MODE) ? 4'h1 : FRAME_OCTETS[m];
            oc <= idx + 4'h1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_start; take |=> frame_start_o && octet_valid_o; endproperty
    a_start: assert property (p_start) else $error("no frame start");
    // Ready comes back while the last octet of a frame is shown
    property p_len;
        octet_valid_o && idx < fq - 4'h1 |=>
            octet_valid_o && !frame_start_o && (frame_ready_o == (idx == fq - 4'h1));
    endproperty
    a_len: assert property (p_len) else $error("frame cut short");
    property p_end; octet_valid_o && idx == fq - 4'h1 |-> frame_ready_o ##1 (!octet_valid_o || frame_start_o); endproperty
    a_end: assert property (p_end) else $error("frame too long");
    property p_en; take |=> lane_en_o == $past(exp_en); endproperty
    a_en: assert property (p_en) else $error("lane mask");
    property p_off; (nz & ~lane_en_o) == 8'h00; endproperty
    a_off: assert property (p_off) else $error("disabled lane active");
    property p_idle; !octet_valid_o |-> nz == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("idle lane active");
    property p_tail; octet_valid_o && fq == 4'h8 && idx == 4'h7 |-> (all & {8{8'h0f}}) == 64'h0; endproperty
    a_tail: assert property (p_tail) else $error("tail not zero");
    property p_m2; take && link_mode_select_i == 4'h2 && chan_cfg_i != CFG_SINGLE |=> lane_1_o == $past(b0_hi); endproperty
    a_m2: assert property (p_m2) else $error("lane 1 octet");

    c_m0: cover property (take && link_mode_select_i == 4'h0);
    c_b2b: cover property (take && octet_valid_o);
    c_bad: cover property (take && link_mode_select_i > LAST_MODE);
endmodule

bind jtm_sample_mapper jtm_sample_mapper_monitor u_mon (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .link_mode_select_i(link_mode_select_i),
    .chan_cfg_i(chan_cfg_i),
    .frame_valid_i(frame_valid_i),
    .sample_i(sample_i),
    .frame_ready_o(frame_ready_o),
    .octet_valid_o(octet_valid_o),
    .frame_start_o(frame_start_o),
    .lane_en_o(lane_en_o),
    .lane_0_o(lane_0_o),
    .lane_1_o(lane_1_o),
    .lane_2_o(lane_2_o),
    .lane_3_o(lane_3_o),
    .lane_4_o(lane_4_o),
    .lane_5_o(lane_5_o),
    .lane_6_o(lane_6_o),
    .lane_7_o(lane_7_o)
);

// ==== verif/jtm_lane_rx.sv ====
// Receiver model: rebuilds each lane frame from the octet stream
`timescale 1ns/1ps
module jtm_lane_rx
    import jtm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Lane stream, lane 0 first
    input wire logic octet_valid_i,
    input wire logic frame_start_i,
    input wire logic [NUM_LANES-1:0][OCTET_W-1:0] lanes_i,
    // Rebuilt frames
    output logic [NUM_LANES-1:0][FRAME_W-1:0] rx_o,
    output logic [CNT_W-1:0] cnt_o,
    output logic [7:0] frames_o
);
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            rx_o <= '0;
            cnt_o <= CNT_RST;
            frames_o <= 8'h00;
        end
        else if (octet_valid_i)
        begin
            for (int i = 0; i < NUM_LANES; i++)
            begin
                if (frame_start_i)
                    rx_o[i] <= {lanes_i[i], 56'h0};
                else
                    rx_o[i][63 - 8 * cnt_o -: 8] <= lanes_i[i];
            end
            cnt_o <= frame_start_i ? 4'h1 : cnt_o + 4'h1;
            frames_o <= frames_o + 8'(frame_start_i);
        end
    end
endmodule

// ==== verif/jtm_sample_mapper_tb_top.sv ====
// Self-checking bench for the transport sample mapper
`timescale 1ns/1ps
module jtm_sample_mapper_tb_top;
    import jtm_pkg::*;
    logic ref_clk_i, rstn_i, frame_valid_i, frame_ready, octet_valid, frame_start;
    logic [MODE_W-1:0] mode;
    logic [1:0] cfg;
    logic [NUM_CH-1:0][SMP_PER_CH-1:0][SMP_W-1:0] smp;
    logic [NUM_LANES-1:0] lane_en;
    logic [NUM_LANES-1:0][OCTET_W-1:0] lanes;
    logic [NUM_LANES-1:0][FRAME_W-1:0] rx;
    logic [CNT_W-1:0] rx_cnt;
    logic [7:0] rx_frames;
    int fails = 0;
    int checks = 0;

    jtm_sample_mapper uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_mode_select_i(mode),
        .chan_cfg_i(cfg), .frame_valid_i(frame_valid_i), .sample_i(smp), .frame_ready_o(frame_ready),
        .octet_valid_o(octet_valid), .frame_start_o(frame_start), .lane_en_o(lane_en),
        .lane_0_o(lanes[0]), .lane_1_o(lanes[1]), .lane_2_o(lanes[2]), .lane_3_o(lanes[3]),
        .lane_4_o(lanes[4]), .lane_5_o(lanes[5]), .lane_6_o(lanes[6]), .lane_7_o(lanes[7]));
    jtm_lane_rx u_rx (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .octet_valid_i(octet_valid),
        .frame_start_i(frame_start), .lanes_i(lanes), .rx_o(rx), .cnt_o(rx_cnt), .frames_o(rx_frames));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Absent channels still carry samples, so zero fill is really exercised
    function automatic logic [11:0] pd(int c, int n, logic [1:0] f);
        int nch = (f == CFG_SINGLE) ? 1 : (f == CFG_DUAL) ? 2 : 4;
        return (c < nch) ? {smp[c][n], 3'h0} : 12'h0;
    endfunction

    function automatic logic [FRAME_W-1:0] exp_frame(logic [3:0] m, logic [1:0] f, int l);
        logic [FRAME_W-1:0] e = '0;
        logic [47:0] g;
        int c = l / 3 * 2;
        case (m)
            4'h0: for (int k = 0; k < 5; k++) e[63 - 12 * k -: 12] = pd(l / 2, l % 2 + 2 * k, f);
            4'h1, 4'h6: g = {pd(c, 0, f), pd(c, 1, f), pd(c + 1, 0, f), pd(c + 1, 1, f)};
            4'h2: e[63 -: 8] = 8'(pd(l, 0, f) >> 4);
            4'h3: e[63 -: 40] = {10'(pd(l, 0, f) >> 2), 10'(pd(l, 1, f) >> 2),
                                 10'(pd(l, 2, f) >> 2), 10'(pd(l, 3, f) >> 2)};
            4'h4: g = (l < 3) ? {pd(0, 0, f), pd(1, 0, f), pd(2, 0, f), pd(3, 0, f)} : 48'h0;
            4'h5: e[63 -: 16] = {8'(pd(2 * l, 0, f) >> 4), 8'(pd(2 * l + 1, 0, f) >> 4)};
            default: e = '0;
        endcase
        if (m == 4'h1 || m == 4'h6 || m == 4'h4)
            e[63 -: 16] = g[47 - 16 * (l % 3) -: 16];
        return e;
    endfunction

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic send(input logic [3:0] m, input logic [1:0] f);
        int nl = (m > 6) ? 0 : (f == CFG_SINGLE) ? LANES_SINGLE[m] : (f == CFG_DUAL) ? LANES_DUAL[m] : LANES_QUAD[m];
        int fo = (m > 6) ? 1 : FRAME_OCTETS[m];
        @(negedge ref_clk_i);
        mode = m;
        cfg = f;
        frame_valid_i = 1'b1;
        @(negedge ref_clk_i);
        frame_valid_i = 1'b0;
        // The receiver takes the last octet one edge after the design shows it
        repeat (fo + 1) @(negedge ref_clk_i);
        chk(lane_en === 8'((9'h1 << nl) - 9'h1), "lane mask");
        chk(rx_cnt === 4'(fo), "octet count");
        for (int l = 0; l < 8; l++)
            chk(rx[l] === exp_frame(m, f, l), "lane frame");
    endtask

    task automatic t_all;
        for (int m = 0; m < 7; m++)
            for (int f = 0; f < 3; f++)
                send(4'(m), 2'(f));
        send(4'h1, 2'h3);
        send(4'h9, CFG_QUAD);
        $display("test all modes done");
    endtask

    task automatic t_b2b;
        logic [7:0] n0 = rx_frames;
        @(negedge ref_clk_i);
        mode = 4'h6;
        cfg = CFG_QUAD;
        frame_valid_i = 1'b1;
        @(negedge ref_clk_i);
        chk(frame_ready === 1'b0, "ready mid frame");
        repeat (3) @(negedge ref_clk_i);
        frame_valid_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        chk(rx_frames === n0 + 8'h2, "frame count");
        for (int l = 0; l < 8; l++)
            chk(rx[l] === exp_frame(4'h6, CFG_QUAD, l), "lane frame");
        $display("test back to back done");
    endtask

    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge ref_clk_i);
        fails++;
        print_verdict;
    end

    initial
    begin
        rstn_i = 1'b0;
        frame_valid_i = 1'b0;
        mode = 4'h0;
        cfg = CFG_QUAD;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 10; n++)
                smp[c][n] = 9'(c * 131 + n * 53 + 7);
        repeat (4) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        t_all;
        t_b2b;
        print_verdict;
    end
endmodule
